//--- src/mmd_pkg.sv
// Package with the memory map, field layouts and types of the memory map decoder
// Summary of operation
// - Reset aliases flash at address zero
// - Clearing alias bit 0 maps SRAM at zero
// - One linear 32-bit byte address space
// - Little endian byte lanes throughout
// - Block 0 at 0x90000, boot page on top
// - Block 1 at 0x80000, all user space
// - Top 2 kB of flash kept for kernel
// - Flash pages are 512 bytes
// - Word fetch from flash takes two halves
// - SRAM is one 32-bit access per word
// - Register space is the top 64 kB
// - AHB access one cycle, APB two cycles
// - Flash control and GPIO on AHB, alias register internal, rest APB
// - Interrupt registers at 0xFFFF0000 and 0xFFFF0100
// - System control at 0xFFFF0200, alias at 0xFFFF0220
// - Four timers from 0xFFFF0300, 0x20 each
// - Power 0x0400, supply monitor 0x0440, reference 0x0480
// - Converter registers at 0xFFFF0500
package mmd_pkg;

  localparam logic [31:0] ALIAS_SIZE       = 32'h0002_0000;
  localparam logic [31:0] SRAM_BASE        = 32'h0004_0000;
  localparam logic [31:0] SRAM_SIZE        = 32'h0000_8000;
  localparam logic [31:0] FLASH_BASE       = 32'h0008_0000;
  localparam logic [31:0] FLASH_BLK0_BASE  = 32'h0009_0000;
  localparam logic [31:0] FLASH_SIZE       = 32'h0002_0000;
  localparam logic [31:0] FLASH_KERNEL_SZ  = 32'h0000_0800;
  localparam logic [31:0] FLASH_KERNEL_OFS = FLASH_SIZE - FLASH_KERNEL_SZ;
  localparam int unsigned FLASH_PAGE_BYTES = 512;
  localparam int unsigned FLASH_PAGE_LSB   = $clog2(FLASH_PAGE_BYTES);
  localparam int unsigned FLASH_BLK_LSB    = 16;

  localparam logic [31:0] PRS_BASE         = 32'hFFFF_0000;
  localparam logic [31:0] IRQ_BASE         = 32'hFFFF_0000;
  localparam logic [31:0] FIQ_BASE         = 32'hFFFF_0100;
  localparam logic [31:0] SYS_BASE         = 32'hFFFF_0200;
  localparam logic [31:0] ALIAS_REG_ADDR   = 32'hFFFF_0220;
  localparam logic [31:0] TMR_BASE         = 32'hFFFF_0300;
  localparam logic [31:0] TMR_SLOT         = 32'h0000_0020;
  localparam logic [31:0] TMR_COUNT        = 32'h0000_0004;
  localparam logic [31:0] PWR_BASE         = 32'hFFFF_0400;
  localparam logic [31:0] PSM_BASE         = 32'hFFFF_0440;
  localparam logic [31:0] REF_BASE         = 32'hFFFF_0480;
  localparam logic [31:0] ADC_BASE         = 32'hFFFF_0500;
  localparam logic [31:0] GPIO_BASE        = 32'hFFFF_F400;
  localparam logic [31:0] FLCTL_BASE       = 32'hFFFF_F800;
  localparam logic [31:0] GRP_SIZE         = 32'h0000_0100;
  localparam logic [31:0] SUB_SIZE         = 32'h0000_0040;

  localparam logic [7:0]  ALIAS_RESET      = 8'h01;
  localparam int unsigned ALIAS_FLASH_BIT  = 0;

  typedef enum logic [1:0] {
    MMD_SZ_BYTE = 2'b00,
    MMD_SZ_HALF = 2'b01,
    MMD_SZ_WORD = 2'b10
  } mmd_size_t;

  typedef enum logic [2:0] {
    MMD_TGT_NONE  = 3'b000,
    MMD_TGT_FLASH = 3'b001,
    MMD_TGT_SRAM  = 3'b010,
    MMD_TGT_AHB   = 3'b011,
    MMD_TGT_APB   = 3'b100,
    MMD_TGT_ALIAS = 3'b101
  } mmd_tgt_t;

  typedef enum logic [3:0] {
    MMD_PER_NONE  = 4'b0000,
    MMD_PER_IRQ   = 4'b0001,
    MMD_PER_FIQ   = 4'b0010,
    MMD_PER_SYS   = 4'b0011,
    MMD_PER_TMR   = 4'b0100,
    MMD_PER_PWR   = 4'b0101,
    MMD_PER_PSM   = 4'b0110,
    MMD_PER_REF   = 4'b0111,
    MMD_PER_ADC   = 4'b1000,
    MMD_PER_GPIO  = 4'b1001,
    MMD_PER_FLCTL = 4'b1010
  } mmd_per_t;

  typedef enum logic [2:0] {
    MMD_ST_IDLE    = 3'b000,
    MMD_ST_FL_LO   = 3'b001,
    MMD_ST_FL_HI   = 3'b010,
    MMD_ST_SRAM    = 3'b011,
    MMD_ST_AHB     = 3'b100,
    MMD_ST_APB_SET = 3'b101,
    MMD_ST_APB_ACC = 3'b110,
    MMD_ST_DONE    = 3'b111
  } mmd_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        wr;
    mmd_size_t   size;
    logic [31:0] wdata;
  } mmd_req_t;

  typedef struct packed {
    mmd_tgt_t    tgt;
    mmd_per_t    per;
    logic [31:0] eff;
    logic        err;
  } mmd_dec_t;

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
    in_range = (a >= base) && ((a - base) < size);
  endfunction

  function automatic logic [3:0] be_of(input mmd_size_t size, input logic [1:0] lsb);
    unique case (size)
      MMD_SZ_BYTE: be_of = 4'h1 << lsb;
      MMD_SZ_HALF: be_of = lsb[1] ? 4'hC : 4'h3;
      default:     be_of = 4'hF;
    endcase
  endfunction

endpackage

//--- src/mmd_flash_join.sv
// Joins two flash half-words into one little endian word
`timescale 1ns/1ps
module mmd_flash_join (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        lo_take,
  input  wire logic [15:0] half_in,
  output logic      [31:0] word
);

  logic [15:0] lo_q;

  // Lower half arrives first and is held for the second access
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      lo_q <= 16'h0000;
    end else if (lo_take) begin
      lo_q <= half_in;
    end
  end

  // Lower address in the low lanes
  assign word = {half_in, lo_q};

endmodule

//--- src/mmd_decoder.sv
// Memory map decoder: boot alias, flash, SRAM and register space routing
`timescale 1ns/1ps
module mmd_decoder
  import mmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cpu_valid,
  input  wire mmd_req_t    cpu_req,
  output logic             cpu_ready,
  output logic      [31:0] cpu_rdata,
  output logic             cpu_err,
  output logic             flash_req,
  output logic             flash_wr,
  output logic             flash_block,
  output logic      [14:0] flash_half_addr,
  output logic      [6:0]  flash_page,
  output logic      [15:0] flash_wdata,
  input  wire logic [15:0] flash_rdata,
  output logic             sram_sel,
  output logic             sram_we,
  output logic      [3:0]  sram_be,
  output logic      [12:0] sram_word_addr,
  output logic      [31:0] sram_wdata,
  input  wire logic [31:0] sram_rdata,
  output mmd_per_t         per_sel,
  output logic      [15:0] per_addr,
  output logic             per_wr,
  output logic      [3:0]  per_be,
  output logic      [31:0] per_wdata,
  input  wire logic [31:0] per_rdata,
  output logic             ahb_sel,
  output logic             apb_sel,
  output logic             apb_enable,
  output logic             boot_from_flash
);

  mmd_state_t  state_q;
  mmd_state_t  state_d;
  mmd_req_t    req_q;
  mmd_dec_t    dec;
  mmd_tgt_t    tgt_q;
  mmd_per_t    per_q;
  logic [31:0] eff_q;
  logic [7:0]  alias_q;
  logic [31:0] rdata_q;
  logic        err_q;
  logic [31:0] flash_word;
  logic [16:0] fl_off;
  logic        fl_word;
  logic        fl_block_ok;
  logic        accept;
  logic [3:0]  req_be;

  assign accept = (state_q == MMD_ST_IDLE) && cpu_valid;
  assign req_be = be_of(cpu_req.size, cpu_req.addr[1:0]);

  // Address decode of the incoming request over the whole 32-bit space
  always_comb begin
    dec     = '0;
    dec.eff = cpu_req.addr;
    dec.tgt = MMD_TGT_NONE;
    dec.per = MMD_PER_NONE;
    dec.err = 1'b1;
    if (cpu_req.addr < ALIAS_SIZE) begin
      if (alias_q[ALIAS_FLASH_BIT]) begin
        dec.eff = FLASH_BASE + cpu_req.addr;
        dec.tgt = MMD_TGT_FLASH;
        dec.err = 1'b0;
      end else if (cpu_req.addr < SRAM_SIZE) begin
        dec.eff = SRAM_BASE + cpu_req.addr;
        dec.tgt = MMD_TGT_SRAM;
        dec.err = 1'b0;
      end
    end else if (in_range(cpu_req.addr, SRAM_BASE, SRAM_SIZE)) begin
      dec.tgt = MMD_TGT_SRAM;
      dec.err = 1'b0;
    end else if (in_range(cpu_req.addr, FLASH_BASE, FLASH_SIZE)) begin
      dec.tgt = MMD_TGT_FLASH;
      dec.err = 1'b0;
    end else if (cpu_req.addr >= PRS_BASE) begin
      // Holes in the register space answer quietly with zero
      dec.err = 1'b0;
      if (cpu_req.addr[31:2] == ALIAS_REG_ADDR[31:2]) begin
        dec.tgt = MMD_TGT_ALIAS;
      end else if (in_range(cpu_req.addr, FLCTL_BASE, GRP_SIZE)) begin
        dec.tgt = MMD_TGT_AHB;
        dec.per = MMD_PER_FLCTL;
      end else if (in_range(cpu_req.addr, GPIO_BASE, GRP_SIZE)) begin
        dec.tgt = MMD_TGT_AHB;
        dec.per = MMD_PER_GPIO;
      end else begin
        dec.tgt = MMD_TGT_APB;
        if (in_range(cpu_req.addr, IRQ_BASE, GRP_SIZE)) begin
          dec.per = MMD_PER_IRQ;
        end else if (in_range(cpu_req.addr, FIQ_BASE, GRP_SIZE)) begin
          dec.per = MMD_PER_FIQ;
        end else if (in_range(cpu_req.addr, SYS_BASE, GRP_SIZE)) begin
          dec.per = MMD_PER_SYS;
        end else if (in_range(cpu_req.addr, TMR_BASE, TMR_SLOT * TMR_COUNT)) begin
          dec.per = MMD_PER_TMR;
        end else if (in_range(cpu_req.addr, PWR_BASE, SUB_SIZE)) begin
          dec.per = MMD_PER_PWR;
        end else if (in_range(cpu_req.addr, PSM_BASE, SUB_SIZE)) begin
          dec.per = MMD_PER_PSM;
        end else if (in_range(cpu_req.addr, REF_BASE, SUB_SIZE)) begin
          dec.per = MMD_PER_REF;
        end else if (in_range(cpu_req.addr, ADC_BASE, GRP_SIZE)) begin
          dec.per = MMD_PER_ADC;
        end else begin
          dec.tgt = MMD_TGT_NONE;
        end
      end
    end
  end

  // Flash view of the captured request
  assign fl_off  = 17'(eff_q - FLASH_BASE);
  assign fl_word = (req_q.size == MMD_SZ_WORD);
  // Kernel area refuses writes; byte writes cannot reach a 16-bit array
  assign fl_block_ok = !req_q.wr ||
                       ((32'(fl_off) < FLASH_KERNEL_OFS) && (req_q.size != MMD_SZ_BYTE));

  // Transfer sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MMD_ST_IDLE: begin
        if (cpu_valid) begin
          unique case (dec.tgt)
            MMD_TGT_FLASH: state_d = MMD_ST_FL_LO;
            MMD_TGT_SRAM:  state_d = MMD_ST_SRAM;
            MMD_TGT_AHB:   state_d = MMD_ST_AHB;
            MMD_TGT_APB:   state_d = MMD_ST_APB_SET;
            default:       state_d = MMD_ST_DONE;
          endcase
        end
      end
      MMD_ST_FL_LO: begin
        if (!fl_block_ok) begin
          state_d = MMD_ST_DONE;
        end else if (fl_word) begin
          state_d = MMD_ST_FL_HI;
        end else begin
          state_d = MMD_ST_DONE;
        end
      end
      MMD_ST_FL_HI:   state_d = MMD_ST_DONE;
      MMD_ST_SRAM:    state_d = MMD_ST_DONE;
      MMD_ST_AHB:     state_d = MMD_ST_DONE;
      MMD_ST_APB_SET: state_d = MMD_ST_APB_ACC;
      MMD_ST_APB_ACC: state_d = MMD_ST_DONE;
      MMD_ST_DONE:    state_d = MMD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= MMD_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Request capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      req_q <= '0;
      tgt_q <= MMD_TGT_NONE;
      per_q <= MMD_PER_NONE;
      eff_q <= 32'h0000_0000;
    end else if (accept) begin
      req_q <= cpu_req;
      tgt_q <= dec.tgt;
      per_q <= dec.per;
      eff_q <= dec.eff;
    end
  end

  // Boot alias select, flash at zero after every reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alias_q <= ALIAS_RESET;
    end else if (accept && (dec.tgt == MMD_TGT_ALIAS) && cpu_req.wr && req_be[0]) begin
      alias_q <= cpu_req.wdata[7:0];
    end
  end

  mmd_flash_join u_join (
    .clk     (clk),
    .reset_n (reset_n),
    .lo_take ((state_q == MMD_ST_FL_LO) && fl_word),
    .half_in (flash_rdata),
    .word    (flash_word)
  );

  // Read data and error capture; writes return zero data
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      unique case (state_q)
        MMD_ST_IDLE: begin
          rdata_q <= 32'h0000_0000;
          err_q   <= cpu_valid && dec.err;
          if (cpu_valid && (dec.tgt == MMD_TGT_ALIAS) && !cpu_req.wr) begin
            rdata_q <= {24'h00_0000, alias_q};
          end
        end
        MMD_ST_FL_LO: begin
          err_q <= !fl_block_ok;
          if (!req_q.wr && !fl_word) begin
            rdata_q <= eff_q[1] ? {flash_rdata, 16'h0000} : {16'h0000, flash_rdata};
          end
        end
        MMD_ST_FL_HI: begin
          if (!req_q.wr) begin
            rdata_q <= flash_word;
          end
        end
        MMD_ST_SRAM: begin
          if (!req_q.wr) begin
            rdata_q <= sram_rdata;
          end
        end
        MMD_ST_AHB: begin
          if (!req_q.wr) begin
            rdata_q <= per_rdata;
          end
        end
        MMD_ST_APB_ACC: begin
          if (!req_q.wr) begin
            rdata_q <= per_rdata;
          end
        end
        MMD_ST_APB_SET: rdata_q <= rdata_q;
        MMD_ST_DONE:    rdata_q <= rdata_q;
      endcase
    end
  end

  assign cpu_ready = (state_q == MMD_ST_DONE);
  assign cpu_rdata = rdata_q;
  assign cpu_err   = err_q;

  // Flash port; word accesses take the even half then the odd half
  assign flash_req       = ((state_q == MMD_ST_FL_LO) && fl_block_ok) || (state_q == MMD_ST_FL_HI);
  assign flash_wr        = flash_req && req_q.wr;
  // Offset bit 16 set means the upper 64 kB, which is block 0
  assign flash_block     = fl_off[FLASH_BLK_LSB];
  assign flash_half_addr = (state_q == MMD_ST_FL_HI) ? {fl_off[15:2], 1'b1} :
                           fl_word ? {fl_off[15:2], 1'b0} : fl_off[15:1];
  assign flash_page      = fl_off[15:FLASH_PAGE_LSB];
  assign flash_wdata     = ((state_q == MMD_ST_FL_HI) || (!fl_word && eff_q[1])) ?
                           req_q.wdata[31:16] : req_q.wdata[15:0];

  // SRAM port, one 32-bit access
  assign sram_sel       = (state_q == MMD_ST_SRAM);
  assign sram_we        = sram_sel && req_q.wr;
  assign sram_be        = be_of(req_q.size, eff_q[1:0]);
  assign sram_word_addr = eff_q[14:2];
  assign sram_wdata     = req_q.wdata;

  // Register space port
  assign per_sel    = per_q;
  assign per_addr   = eff_q[15:0];
  assign per_wr     = req_q.wr;
  assign per_be     = be_of(req_q.size, eff_q[1:0]);
  assign per_wdata  = req_q.wdata;
  assign ahb_sel    = (state_q == MMD_ST_AHB);
  assign apb_sel    = (state_q == MMD_ST_APB_SET) || (state_q == MMD_ST_APB_ACC);
  assign apb_enable = (state_q == MMD_ST_APB_ACC);

  assign boot_from_flash = alias_q[ALIAS_FLASH_BIT];

endmodule

//--- dv/mmd_decoder_assertions.sv
// Checker for the memory map decoder port timing and routing
`timescale 1ns/1ps
module mmd_decoder_checker
  import mmd_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        cpu_ready,
  input wire logic        flash_req,
  input wire logic        flash_wr,
  input wire logic        flash_block,
  input wire logic [14:0] flash_half_addr,
  input wire logic [6:0]  flash_page,
  input wire logic        sram_sel,
  input wire mmd_per_t    per_sel,
  input wire logic        ahb_sel,
  input wire logic        apb_sel,
  input wire logic        apb_enable,
  input wire logic        boot_from_flash
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_APB_TWO: assert property ($rose(apb_sel) |-> !apb_enable ##1 (apb_sel && apb_enable) ##1 (!apb_sel && cpu_ready))
    else $error("peripheral bus access not two cycles");
  AST_AHB_ONE: assert property (ahb_sel |=> cpu_ready && !ahb_sel)
    else $error("fast bus access not one cycle");
  AST_AHB_ROUTE: assert property (ahb_sel |-> per_sel inside {MMD_PER_GPIO, MMD_PER_FLCTL})
    else $error("wrong group on fast bus");
  AST_APB_ROUTE: assert property (apb_sel |-> !(per_sel inside {MMD_PER_GPIO, MMD_PER_FLCTL, MMD_PER_NONE}))
    else $error("wrong group on peripheral bus");
  AST_FLASH_PAIR: assert property (flash_req && $past(flash_req) |->
      flash_half_addr == $past(flash_half_addr) + 15'h0001 && flash_block == $past(flash_block))
    else $error("second flash half not adjacent");
  AST_FLASH_PAGE: assert property (flash_req |-> flash_page == flash_half_addr[14:8])
    else $error("flash page index wrong");
  AST_BOOT_RESET: assert property ($rose(reset_n) |-> boot_from_flash)
    else $error("flash not aliased after reset");
  AST_KERNEL_WR: assert property (flash_req && flash_wr |-> !(flash_block && flash_half_addr >= 15'h7C00))
    else $error("write reached reserved flash");
  AST_READY_PULSE: assert property (cpu_ready |=> !cpu_ready)
    else $error("ready longer than one cycle");
  AST_ONE_TARGET: assert property ($onehot0({flash_req, sram_sel, ahb_sel, apb_sel}))
    else $error("two targets strobed together");
  AST_SRAM_ONE: assert property (sram_sel |=> cpu_ready && !sram_sel)
    else $error("static memory access not single");
endmodule

bind mmd_decoder mmd_decoder_checker u_chk (.clk(clk), .reset_n(reset_n), .cpu_ready(cpu_ready),
  .flash_req(flash_req), .flash_wr(flash_wr), .flash_block(flash_block), .flash_half_addr(flash_half_addr),
  .flash_page(flash_page), .sram_sel(sram_sel), .per_sel(per_sel), .ahb_sel(ahb_sel), .apb_sel(apb_sel),
  .apb_enable(apb_enable), .boot_from_flash(boot_from_flash));

//--- dv/mmd_mem_model.sv
// Behavioural flash, static memory and register banks behind the decoder
`timescale 1ns/1ps
module mmd_mem_model
  import mmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        flash_req,
  input  wire logic        flash_block,
  input  wire logic [14:0] flash_half_addr,
  output logic      [15:0] flash_rdata,
  input  wire logic        sram_sel,
  input  wire logic        sram_we,
  input  wire logic [3:0]  sram_be,
  input  wire logic [12:0] sram_word_addr,
  input  wire logic [31:0] sram_wdata,
  output logic      [31:0] sram_rdata,
  input  wire mmd_per_t    per_sel,
  input  wire logic [15:0] per_addr,
  input  wire logic        ahb_sel,
  input  wire logic        apb_sel,
  output logic      [31:0] per_rdata
);
  logic [31:0] mem [8192];
  logic [15:0] fl_last;
  logic [31:0] sr_last;
  logic [31:0] pr_last;
  // Idle lines show the inverse of the last value, so stale data never matches
  assign flash_rdata = flash_req ? {flash_block, flash_half_addr} : ~fl_last;
  assign sram_rdata  = sram_sel ? mem[sram_word_addr] : ~sr_last;
  assign per_rdata   = (ahb_sel || apb_sel) ? {per_sel, 12'h000, per_addr} : ~pr_last;
  always @(posedge clk) begin
    fl_last <= flash_rdata;
    sr_last <= sram_rdata;
    pr_last <= per_rdata;
    if (sram_sel && sram_we) begin
      for (int b = 0; b < 4; b++) begin
        if (sram_be[b]) mem[sram_word_addr][8*b +: 8] <= sram_wdata[8*b +: 8];
      end
    end
  end
endmodule

//--- dv/mmd_decoder_test.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
module mmd_decoder_test;
  import mmd_pkg::*;
  logic clk, reset_n, cpu_valid, cpu_ready, cpu_err, flash_req, flash_block, sram_sel, sram_we, ahb_sel, apb_sel;
  logic        flash_wr, per_wr, apb_enable, boot_flash;
  logic [15:0] flash_wdata;
  logic [31:0] per_wdata;
  logic [3:0]  per_be;
  logic [31:0] fw_q = 32'h0000_0000;
  logic [31:0] pw_q = 32'h0000_0000;
  logic [3:0]  pb_q = 4'h0;
  logic [31:0] cpu_rdata, sram_wdata, sram_rdata, per_rdata, r;
  logic [15:0] flash_rdata, per_addr;
  logic [14:0] flash_half_addr;
  logic [12:0] sram_word_addr;
  logic [3:0]  sram_be;
  logic        e;
  mmd_req_t    cpu_req;
  mmd_per_t    per_sel;
  int          n, err_total, checks_done, cyc;
  logic [31:0] pa [10] = '{32'hFFFF_0008, 32'hFFFF_0100, 32'hFFFF_0230, 32'hFFFF_0360, 32'hFFFF_0404,
                           32'hFFFF_0444, 32'hFFFF_048C, 32'hFFFF_0510, 32'hFFFF_F400, 32'hFFFF_F800};

  mmd_decoder dut (.clk(clk), .reset_n(reset_n), .cpu_valid(cpu_valid), .cpu_req(cpu_req),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .cpu_err(cpu_err), .flash_req(flash_req), .flash_wr(flash_wr),
    .flash_block(flash_block), .flash_half_addr(flash_half_addr), .flash_page(), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata), .sram_sel(sram_sel), .sram_we(sram_we), .sram_be(sram_be),
    .sram_word_addr(sram_word_addr), .sram_wdata(sram_wdata), .sram_rdata(sram_rdata), .per_sel(per_sel),
    .per_addr(per_addr), .per_wr(per_wr), .per_be(per_be), .per_wdata(per_wdata), .per_rdata(per_rdata),
    .ahb_sel(ahb_sel), .apb_sel(apb_sel), .apb_enable(apb_enable), .boot_from_flash(boot_flash));
  mmd_mem_model u_mem (.clk(clk), .flash_req(flash_req), .flash_block(flash_block),
    .flash_half_addr(flash_half_addr), .flash_rdata(flash_rdata), .sram_sel(sram_sel), .sram_we(sram_we),
    .sram_be(sram_be), .sram_word_addr(sram_word_addr), .sram_wdata(sram_wdata), .sram_rdata(sram_rdata),
    .per_sel(per_sel), .per_addr(per_addr), .ahb_sel(ahb_sel), .apb_sel(apb_sel), .per_rdata(per_rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Last write seen on the flash port and on the register buses
  always @(posedge clk) begin
    if (flash_req && flash_wr) begin
      fw_q <= {flash_block, flash_half_addr, flash_wdata};
    end
    if ((ahb_sel || apb_enable) && per_wr) begin
      pw_q <= per_wdata;
      pb_q <= per_be;
    end
  end

  task automatic acc(input logic [31:0] a, input logic w, input mmd_size_t s, input logic [31:0] d);
    @(posedge clk);
    #1;
    cpu_valid = 1'b1;
    cpu_req = '{a, w, s, d};
    n = -1;
    do begin
      @(negedge clk);
      n++;
    end while (cpu_ready !== 1'b1 && n < 20);
    chk({31'h0, cpu_ready}, 32'h0000_0001);
    r = cpu_rdata;
    e = cpu_err;
    @(posedge clk);
    #1 cpu_valid = 1'b0;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Ceiling well above the 140 or so cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      conclude();
    end
  end

  initial begin
    reset_n = 1'b0;
    cpu_valid = 1'b0;
    cpu_req = '0;
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    chk({31'h0, boot_flash}, 32'h0000_0001);
    acc(ALIAS_REG_ADDR, 1'b0, MMD_SZ_WORD, 32'h0);
    chk(r, 32'h0000_0001);
    chk(32'(n), 32'h0000_0001);
    acc(32'h0000_0008, 1'b0, MMD_SZ_WORD, 32'h0);
    chk(r, 32'h0005_0004);
    acc(32'h0009_0008, 1'b0, MMD_SZ_WORD, 32'h0);
    chk(r, 32'h8005_8004);
    chk(32'(n), 32'h0000_0003);
    acc(32'h0008_0004, 1'b0, MMD_SZ_WORD, 32'h0);
    chk(r, 32'h0003_0002);
    acc(32'h0004_0010, 1'b1, MMD_SZ_WORD, 32'h1122_3344);
    acc(32'h0004_0012, 1'b1, MMD_SZ_BYTE, 32'h00AA_0000);
    acc(32'h0004_0010, 1'b0, MMD_SZ_WORD, 32'h0);
    chk(r, 32'h11AA_3344);
    chk(32'(n), 32'h0000_0002);
    acc(ALIAS_REG_ADDR, 1'b1, MMD_SZ_BYTE, 32'h0);
    chk({31'h0, boot_flash}, 32'h0);
    acc(32'h0000_0010, 1'b0, MMD_SZ_WORD, 32'h0);
    chk(r, 32'h11AA_3344);
    acc(32'h0001_0010, 1'b0, MMD_SZ_WORD, 32'h0);
    chk({31'h0, e}, 32'h0000_0001);
    // A reset in mid-run must bring flash back at zero
    @(posedge clk);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    chk({31'h0, boot_flash}, 32'h0000_0001);
    acc(32'h0000_0008, 1'b0, MMD_SZ_WORD, 32'h0);
    chk(r, 32'h0005_0004);
    acc(ALIAS_REG_ADDR, 1'b1, MMD_SZ_BYTE, 32'h0000_0001);
    for (int i = 0; i < 10; i++) begin
      acc(pa[i], 1'b0, MMD_SZ_WORD, 32'h0);
      chk(r, {4'(i + 1), 12'h000, pa[i][15:0]});
      chk(32'(n), (i >= 8) ? 32'h0000_0002 : 32'h0000_0003);
    end
    acc(32'hFFFF_0600, 1'b1, MMD_SZ_WORD, 32'hFFFF_FFFF);
    acc(32'hFFFF_0600, 1'b0, MMD_SZ_WORD, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h0);
    chk(32'(n), 32'h0000_0001);
    acc(32'hFFFF_0361, 1'b1, MMD_SZ_BYTE, 32'h0000_5A00);
    chk(pw_q, 32'h0000_5A00);
    chk({28'h0, pb_q}, 32'h0000_0002);
    acc(32'h0009_F800, 1'b1, MMD_SZ_HALF, 32'h0000_5A5A);
    chk({31'h0, e}, 32'h0000_0001);
    chk(fw_q, 32'h0000_0000);
    acc(32'h0009_F800, 1'b0, MMD_SZ_HALF, 32'h0);
    chk({31'h0, e}, 32'h0);
    chk(32'(n), 32'h0000_0002);
    acc(32'h0008_0202, 1'b1, MMD_SZ_HALF, 32'h1234_0000);
    chk({31'h0, e}, 32'h0);
    chk(fw_q, 32'h0101_1234);
    acc(32'h0010_0000, 1'b0, MMD_SZ_WORD, 32'h0);
    chk({31'h0, e}, 32'h0000_0001);
    conclude();
  end
endmodule
